// ### bench/qdc_chk.sv
// Checker for the decoder register port and interrupt level.
// Bound to qdc_decoder; sees its ports only.
`timescale 1ns/1ps
module qdc_chk
  import qdc_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [7:0]  i_port,
  input wire logic [1:0]  o_irq_level
);
  localparam logic [11:0] A_C = {2'h0, QDC_IDX_CTRL, 2'h0};
  logic [7:0] c_q;
  logic [7:0] c_d;
  logic       s;
  logic       m;
  // Shadow of the control register
  always_comb begin
    c_d = c_q;
    if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == A_C) begin
      c_d = i_pwdata[7:0];
    end
  end
  always_ff @(posedge i_mclk) begin
    c_q <= i_resetn ? c_d : 8'h00;
  end
  // Setup phase and mapped address
  assign s = i_psel && !i_penable;
  assign m = i_paddr inside {A_C, 12'h240, 12'h250, 12'h258};
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  property p_rdy; s |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  property p_pls; o_pready |=> !o_pready; endproperty
  a_pls: assert property (p_pls) else $error("long ready");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_hi; o_pready |-> o_prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper data set");
  property p_um; s && !m |=> o_pslverr && o_prdata == 32'h0; endproperty
  a_um: assert property (p_um) else $error("unmapped ok");
  property p_mp; s && m |=> !o_pslverr; endproperty
  a_mp: assert property (p_mp) else $error("mapped error");
  property p_cr; s && !i_pwrite && i_paddr == A_C |=> o_prdata[7:0] == c_q; endproperty
  a_cr: assert property (p_cr) else $error("ctrl readback");
  property p_irq;
    o_irq_level != 2'h0 |-> o_irq_level == c_q[1:0];
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  c_um: cover property (o_pslverr);
  c_irq: cover property (o_irq_level == 2'h3);
  c_cr: cover property (s && i_paddr == A_C);
endmodule
bind qdc_decoder qdc_chk chk_u (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_port(i_port),
  .o_irq_level(o_irq_level));

// ### bench/qdc_decoder_tb.sv
// Testbench for the quadrature decoder over APB.
// Assumes the encoder model drives one selected pin pair.
`timescale 1ns/1ps
module qdc_decoder_tb;
  import qdc_pkg::*;
  localparam int DIV = 2;
  localparam logic [11:0] A_F = {2'h0, QDC_IDX_FLAGS, 2'h0};
  localparam logic [11:0] A_C = {2'h0, QDC_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_1 = {2'h0, QDC_IDX_CNT1, 2'h0};
  localparam logic [11:0] A_2 = {2'h0, QDC_IDX_CNT2, 2'h0};
  logic i_mclk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, er;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rdv;
  logic o_pready, o_pslverr, step = 0, up = 0;
  logic [7:0] i_port = 0, noise = 0;
  logic [7:0] e[2];
  logic [1:0] o_irq_level, iq;
  int lo = 0, mismatches = 0, compares = 0;
  qdc_decoder #(.SAMPLE_DIV(DIV)) dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_port(i_port), .o_irq_level(o_irq_level));
  qdc_enc_model enc_u (.i_mclk(i_mclk), .i_step(step), .i_up(up), .o_iq(iq));
  initial forever #4 i_mclk = ~i_mclk;
  // Encoder pair lands at bit lo, I on the odd bit
  always @(posedge i_mclk) i_port <= ({6'h0, iq} << lo) ^ noise;
  task close_out;
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(string n, logic [31:0] s, logic [31:0] x);
    compares++;
    if (s !== x) begin
      mismatches++;
      $display("FAIL %s exp %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer, held until ready
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    @(posedge i_mclk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, d};
    @(posedge i_mclk);
    i_penable <= 1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      chk("pready", o_pready, 1);
      close_out();
    end else begin
      rdv = o_prdata;
      er = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
    end
  endtask
  task rd(string n, logic [11:0] a, logic [31:0] x);
    apb(0, a, 0);
    chk(n, rdv, x);
  endtask
  task mv(int k, logic u);
    repeat (k) begin
      @(posedge i_mclk);
      {step, up} <= {1'b1, u};
      @(posedge i_mclk);
      step <= 0;
      repeat (2 * DIV + 6) @(posedge i_mclk);
    end
  endtask
  task t_map;
    rd("ctrl", A_C, 0);
    rd("cnt2", A_2, 0);
    apb(1, A_C, 32'h30);
    rd("ctrl", A_C, 32'h30);
    apb(1, A_1, 32'h5a);
    rd("cnt1", A_1, 0);
    apb(0, 12'h248, 0);
    chk("slverr", er, 1);
  endtask
  task t_sel;
    logic [7:0] c[4] = '{8'h08, 8'h0c, 8'h80, 8'hc0};
    int l[4] = '{0, 4, 2, 6};
    for (int i = 0; i < 4; i++) begin
      lo = l[i];
      apb(1, A_C, c[i]);
      mv(5, 1);
      mv(1, 0);
      e[i / 2] += 8'h04;
      rd("cnt1", A_1, e[0]);
      rd("cnt2", A_2, e[1]);
    end
  endtask
  task t_dis;
    logic [7:0] on[2] = '{8'h08, 8'hc0};
    logic [7:0] off[2] = '{8'h04, 8'h40};
    int l[2] = '{0, 6};
    for (int i = 0; i < 2; i++) begin
      lo = l[i];
      apb(1, A_C, on[i]);
      mv(1, 1);
      apb(1, A_C, off[i]);
      mv(1, 1);
      apb(1, A_C, on[i]);
      mv(2, 1);
      e[i] += 8'h03;
      rd("cnt1", A_1, e[0]);
      rd("cnt2", A_2, e[1]);
    end
    // Zero count two, then a two-cycle pin glitch that only the tick filter can stop
    apb(1, A_F, 32'h10);
    e[1] = 8'h00;
    @(posedge i_mclk);
    noise <= 8'h80;
    repeat (2) @(posedge i_mclk);
    noise <= 0;
    repeat (2 * DIV + 6) @(posedge i_mclk);
    rd("glitch flags", A_F, 0);
    rd("cnt2 zeroed", A_2, e[1]);
    mv(1, 1);
    e[1] += 8'h01;
    rd("glitch", A_2, e[1]);
  endtask
  task t_wrap;
    lo = 0;
    apb(1, A_F, 32'h01);
    for (int p = 0; p < 4; p++) begin
      apb(1, A_C, {28'h0, 2'b10, p[1:0]});
      mv(1, p[0]);
      repeat (2) @(posedge i_mclk);
      chk("irq", o_irq_level, p);
      rd("flags", A_F, p[0] ? 8'h08 : 8'h04);
      repeat (2) @(posedge i_mclk);
      chk("irq clr", o_irq_level, 0);
      rd("cnt1", A_1, p[0] ? 8'h00 : 8'hff);
    end
  endtask
  initial begin
    e = '{8'h00, 8'h00};
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1;
    t_map;
    t_sel;
    t_dis;
    t_wrap;
    close_out;
  end
endmodule

// ### bench/qdc_enc_model.sv
// Encoder model: one quadrature pair stepped on command.
// Assumes the bench spaces steps by several sample ticks.
`timescale 1ns/1ps
module qdc_enc_model (
  input wire logic       i_mclk,
  input wire logic       i_step,
  input wire logic       i_up,
  output logic     [1:0] o_iq
);
  logic [1:0] ph_q = 2'h0;
  // Phase walks 00,01,11,10 in I,Q order when counting up
  always @(posedge i_mclk) begin
    if (i_step) ph_q <= i_up ? ph_q + 2'h1 : ph_q - 2'h1;
  end
  assign o_iq = {ph_q[1], ph_q[1] ^ ph_q[0]};
endmodule

// ### core/qdc_decoder.sv
// Quadrature decoder: APB registers, input select, filter, counters, wrap flags.
// Assumes i_port comes from pins asynchronous to i_mclk; APB master on i_mclk.
`timescale 1ns/1ps

module qdc_decoder #(
  parameter int unsigned SAMPLE_DIV = qdc_pkg::QDC_SAMPLE_DIV
) (
  // Clock and reset
  input  wire logic                            i_mclk,
  input  wire logic                            i_resetn,
  // APB slave
  input  wire logic                            i_psel,
  input  wire logic                            i_penable,
  input  wire logic                            i_pwrite,
  input  wire logic [qdc_pkg::QDC_ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]                     i_pwdata,
  output logic      [31:0]                     o_prdata,
  output logic                                 o_pready,
  output logic                                 o_pslverr,
  // Encoder input port
  input  wire logic [7:0]                      i_port,
  // Interrupt request level, zero when idle
  output logic      [1:0]                      o_irq_level
);
  import qdc_pkg::*;

  localparam int unsigned DIV_W = (SAMPLE_DIV < 2) ? 1 : $clog2(SAMPLE_DIV);

  // Register address match on the word index
  function automatic logic hit(input logic [QDC_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[1:0] == 2'h0) && (a[QDC_ADDR_W-1:2] == {2'h0, idx});
  endfunction

  // Input pair for a selection code: odd bit is in-phase, even is quadrature
  function automatic logic [1:0] pick(input logic [7:0] p, input logic [1:0] sel,
                                      input int unsigned lo, input int unsigned hi);
    if (sel[0]) begin
      pick = {p[hi+1], p[hi]};
    end else begin
      pick = {p[lo+1], p[lo]};
    end
  endfunction

  // Synchroniser and sample divider state
  logic [7:0]        sy1_q, sy2_q, sy3_q, stab_q, stab_d;
  logic [DIV_W-1:0]  div_q, div_d;
  logic              tick_q, tick_d;

  // Bus, control and decoder state
  logic [7:0]        ctrl_q, ctrl_d;
  logic [7:0]        flags_q, flags_d;
  logic [31:0]       prdata_q, prdata_d;
  logic              pready_q, pready_d;
  logic              pslverr_q, pslverr_d;
  logic [1:0]        irq_q, irq_d;
  qdc_chan_type      ch_q [2];
  qdc_chan_type      ch_d [2];

  // Synchroniser acceptance and sample tick
  always_comb begin
    stab_d = stab_q;
    if (sy2_q == sy3_q) begin
      stab_d = sy3_q;
    end
    tick_d = 1'b0;
    div_d  = div_q + DIV_W'(1);
    if (div_q == DIV_W'(SAMPLE_DIV - 1)) begin
      div_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      sy1_q  <= 8'h00;
      sy2_q  <= 8'h00;
      sy3_q  <= 8'h00;
      stab_q <= 8'h00;
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      sy1_q  <= i_port;
      sy2_q  <= sy1_q;
      sy3_q  <= sy2_q;
      stab_q <= stab_d;
      div_q  <= div_d;
      tick_q <= tick_d;
    end
  end

  // Bus access, channel decode, flags and interrupt
  always_comb begin
    logic        acc;
    logic        wr;
    logic [7:0]  set;
    logic [7:0]  clr;
    logic [1:0]  sel;
    logic [1:0]  smp;
    logic        step;
    logic        up;
    acc       = i_psel && i_penable && pready_q;
    wr        = acc && i_pwrite;
    set       = 8'h00;
    clr       = 8'h00;
    sel       = 2'h0;
    smp       = 2'h0;
    step      = 1'b0;
    up        = 1'b0;
    ctrl_d    = ctrl_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    ch_d      = ch_q;

    // Setup phase: answer registered for the first access cycle
    if (i_psel && !i_penable) begin
      pready_d  = 1'b1;
      prdata_d  = 32'h0000_0000;
      if (hit(i_paddr, QDC_IDX_FLAGS)) begin
        prdata_d[7:0] = flags_q & 8'hcc;
      end else if (hit(i_paddr, QDC_IDX_CTRL)) begin
        prdata_d[7:0] = ctrl_q;
      end else if (hit(i_paddr, QDC_IDX_CNT1)) begin
        prdata_d[7:0] = ch_q[0].count;
      end else if (hit(i_paddr, QDC_IDX_CNT2)) begin
        prdata_d[7:0] = ch_q[1].count;
      end else begin
        pslverr_d = 1'b1;
      end
    end

    // Control write; bits 5:4 stored but ignored by the logic
    if (wr && hit(i_paddr, QDC_IDX_CTRL)) begin
      ctrl_d = i_pwdata[7:0];
    end
    // Reading flags clears exactly the bits that were returned
    if (acc && !i_pwrite && hit(i_paddr, QDC_IDX_FLAGS)) begin
      clr = prdata_q[7:0];
    end

    // Channel decoders on the sample tick
    for (int c = 0; c < 2; c++) begin
      sel = (c == 0) ? ctrl_q[QDC_CTRL_SEL1 +: 2] : ctrl_q[QDC_CTRL_SEL2 +: 2];
      smp = (c == 0) ? pick(stab_q, sel, 0, 4) : pick(stab_q, sel, 2, 6);
      if (tick_q && sel[1]) begin
        if (sel != ch_q[c].sel_used) begin
          // New or changed source: reload state silently
          ch_d[c].sel_used = sel;
          ch_d[c].prev     = smp;
          ch_d[c].filt     = smp;
        end else begin
          ch_d[c].prev = smp;
          if (smp == ch_q[c].prev && smp != ch_q[c].filt) begin
            ch_d[c].filt = smp;
            step = (smp[0] ^ ch_q[c].filt[0]) ^ (smp[1] ^ ch_q[c].filt[1]);
            up   = ch_q[c].filt[1] ^ smp[0];
            if (step && up) begin
              ch_d[c].count = ch_q[c].count + QDC_CNT_W'(1);
              if (ch_q[c].count == {QDC_CNT_W{1'b1}}) begin
                set[(c == 0) ? QDC_FLG1_INC : QDC_FLG2_INC] = 1'b1;
              end
            end else if (step) begin
              ch_d[c].count = ch_q[c].count - QDC_CNT_W'(1);
              if (ch_q[c].count == '0) begin
                set[(c == 0) ? QDC_FLG1_DEC : QDC_FLG2_DEC] = 1'b1;
              end
            end
          end
        end
      end else if (!sel[1]) begin
        ch_d[c].sel_used = 2'h0;
      end
    end

    // Counter reset through the flags register, no flag raised
    if (wr && hit(i_paddr, QDC_IDX_FLAGS)) begin
      if (i_pwdata[QDC_CLR1_BIT]) begin
        ch_d[0].count = '0;
        set[QDC_FLG1_INC] = 1'b0;
        set[QDC_FLG1_DEC] = 1'b0;
      end
      if (i_pwdata[QDC_CLR2_BIT]) begin
        ch_d[1].count = '0;
        set[QDC_FLG2_INC] = 1'b0;
        set[QDC_FLG2_DEC] = 1'b0;
      end
    end

    // Set wins over the read clear
    flags_d = (flags_q & ~clr) | set;
    irq_d   = (|flags_d) ? ctrl_d[QDC_CTRL_PRIO +: 2] : 2'h0;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_resetn) begin
      ctrl_q    <= QDC_CTRL_RST;
      flags_q   <= 8'h00;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 2'h0;
      ch_q[0]   <= '0;
      ch_q[1]   <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      flags_q   <= flags_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q     <= irq_d;
      ch_q[0]   <= ch_d[0];
      ch_q[1]   <= ch_d[1];
    end
  end

  // Outputs straight from flops
  assign o_prdata    = prdata_q;
  assign o_pready    = pready_q;
  assign o_pslverr   = pslverr_q;
  assign o_irq_level = irq_q;

endmodule

// ### core/qdc_pkg.sv
// Package for the two-channel quadrature decoder block.
// Assumes a 32-bit APB slave, word-aligned registers, byte address = 4 * index.
package qdc_pkg;

  // Register indices and bus geometry
  localparam int unsigned        QDC_ADDR_W     = 12;
  localparam logic [7:0]         QDC_IDX_FLAGS  = 8'h90;
  localparam logic [7:0]         QDC_IDX_CTRL   = 8'h91;
  localparam logic [7:0]         QDC_IDX_CNT1   = 8'h94;
  localparam logic [7:0]         QDC_IDX_CNT2   = 8'h96;

  // Control field positions and reset value
  localparam int unsigned        QDC_CTRL_PRIO  = 0;
  localparam int unsigned        QDC_CTRL_SEL1  = 2;
  localparam int unsigned        QDC_CTRL_SEL2  = 6;
  localparam logic [7:0]         QDC_CTRL_RST   = 8'h00;

  // Wrap flag and counter reset bit positions
  localparam int unsigned        QDC_FLG1_DEC   = 2;
  localparam int unsigned        QDC_FLG1_INC   = 3;
  localparam int unsigned        QDC_FLG2_DEC   = 6;
  localparam int unsigned        QDC_FLG2_INC   = 7;
  localparam int unsigned        QDC_CLR1_BIT   = 0;
  localparam int unsigned        QDC_CLR2_BIT   = 4;

  // Sample clock divider: peripheral clocks per sample tick, at least two
  localparam int unsigned        QDC_SAMPLE_DIV = 2;
  localparam int unsigned        QDC_CNT_W      = 8;

  // Per-channel decoder state
  typedef struct packed {
    logic [1:0]           sel_used;
    logic [1:0]           prev;
    logic [1:0]           filt;
    logic [QDC_CNT_W-1:0] count;
  } qdc_chan_type;

endpackage
